/* rtl/dmc_drive_cmd.sv */
// Speed-feed command handshake, brake request and monitor selection
// Functional notes
// - Drive flags write done with reply code
// - Run command opens brake and accelerates
// - Run release decelerates, then closes brake
// - Ramp times from full-closed pattern set
// - Monitor item chosen by selection code
// - Code 39 gives compensation count
// - Code 52 gives compensation plus model speed
// - Code 54 gives distance meter fault
// - Code 67 gives filtered crane speed
// - Code 81 gives model speed command
// - Code 91 gives generated output speed
// - Code 92 adds droop compensation
// - Codes 93, 94 give position command
// - Codes 95, 96 give current position
// - Code 97 gives system failure code
// - Serial reads never show negative sign
// - Sign shown only when enabled
// - Speed items zero without full-closed control
// - Position command zero when feed off, stopped
`default_nettype none
`include "dmc_defs.svh"
module dmc_drive_cmd #(
    parameter int W = 16,
    parameter int STEP = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic freq_write_request_bit_a,
    input wire logic [W-1:0] speedCommand,
    input wire logic forward_run_command,
    input wire logic reverse_run_command,
    input wire logic [W-1:0] rampAccelStep,
    input wire logic [W-1:0] rampDecelStep,
    input wire logic speedFeedMode,
    input wire logic fullClosedEn,
    input wire logic positionFeedEn,
    input wire logic negOutEn,
    input wire logic serialRead,
    input wire logic [7:0] selCode,
    input wire logic selWrite,
    input wire logic compEvent,
    input wire logic [W-1:0] posLoopComp,
    input wire logic [W-1:0] meterFault,
    input wire logic [W-1:0] craneSpeed,
    input wire logic [W-1:0] droopComp,
    input wire logic [31:0] posCmd,
    input wire logic [31:0] curPos,
    input wire logic [W-1:0] sysFault,
    output logic freq_write_done_bit_b,
    output logic [W-1:0] reply_code_word_a,
    output logic brake_open_request,
    output logic [W-1:0] modelSpeed,
    output logic speedFeedStatus,
    output logic [7:0] activeSel,
    output logic [W-1:0] monValue,
    output logic monNegative
);
    localparam logic [15:0] STOP_CYC = 16'(`DMC_STOP_CYCLES);

    dmc_pkg::dmc_run_e state;
    dmc_pkg::dmc_run_e next_state;
    logic [1:0] wrSync;
    logic [1:0] fwdSync;
    logic [1:0] revSync;
    logic wrPrev;
    logic [W-1:0] setFreq;
    logic [W-1:0] compCount;
    logic runPrev;
    logic [15:0] stopCount;
    logic runCmd;
    logic wrReq;
    logic atSpeed;
    logic atZero;

    ////////////////////////////////////////////////////////////////////////
    // Network bits come from another domain
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrSync <= 2'h0;
            fwdSync <= 2'h0;
            revSync <= 2'h0;
        end else begin
            wrSync <= {wrSync[0], freq_write_request_bit_a};
            fwdSync <= {fwdSync[0], forward_run_command};
            revSync <= {revSync[0], reverse_run_command};
        end
    end

    assign wrReq = wrSync[1];
    assign runCmd = fwdSync[1] | revSync[1];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            speedFeedStatus <= 1'b0;
        end else begin
            speedFeedStatus <= speedFeedMode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frequency write handshake: done follows the request level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPrev <= 1'b0;
            setFreq <= '0;
            freq_write_done_bit_b <= 1'b0;
            reply_code_word_a <= `DMC_REPLY_OK;
        end else begin
            wrPrev <= wrReq;
            if (wrReq && !wrPrev) begin
                setFreq <= speedCommand;
                freq_write_done_bit_b <= 1'b1;
                // Busy reply outside speed feed; setFreq is still loaded with the value
                reply_code_word_a <= speedFeedStatus ? `DMC_REPLY_OK : `DMC_REPLY_BUSY;
            end else if (!wrReq) begin
                freq_write_done_bit_b <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Run sequence and linear model speed ramp
    assign atSpeed = modelSpeed >= setFreq;
    assign atZero = modelSpeed == '0;

    always_comb begin
        next_state = state;
        case (state)
            dmc_pkg::DMC_IDLE: if (runCmd) next_state = dmc_pkg::DMC_ACCEL;
            dmc_pkg::DMC_ACCEL: begin
                if (!runCmd) next_state = dmc_pkg::DMC_DECEL;
                else if (atSpeed) next_state = dmc_pkg::DMC_RUN;
            end
            dmc_pkg::DMC_RUN: if (!runCmd) next_state = dmc_pkg::DMC_DECEL;
            dmc_pkg::DMC_DECEL: begin
                if (runCmd) next_state = dmc_pkg::DMC_ACCEL;
                else if (atZero && stopCount == '0) next_state = dmc_pkg::DMC_IDLE;
            end
            default: next_state = dmc_pkg::DMC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= dmc_pkg::DMC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Ramp steps stand for the full-closed pattern times
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            modelSpeed <= '0;
        end else begin
            case (state)
                dmc_pkg::DMC_ACCEL: begin
                    if (setFreq - modelSpeed > rampAccelStep) modelSpeed <= W'(modelSpeed + rampAccelStep);
                    else modelSpeed <= setFreq;
                end
                dmc_pkg::DMC_RUN: modelSpeed <= setFreq;
                dmc_pkg::DMC_DECEL: begin
                    if (modelSpeed > rampDecelStep) modelSpeed <= W'(modelSpeed - rampDecelStep);
                    else modelSpeed <= '0;
                end
                default: modelSpeed <= '0;
            endcase
        end
    end

    // Settle time at zero before dropping the brake request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stopCount <= STOP_CYC;
        end else if (state == dmc_pkg::DMC_DECEL && atZero) begin
            if (stopCount != '0) stopCount <= stopCount - 16'h0001;
        end else begin
            stopCount <= STOP_CYC;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            brake_open_request <= 1'b0;
        end else begin
            brake_open_request <= next_state != dmc_pkg::DMC_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compensation count restarts on each run assertion
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            runPrev <= 1'b0;
            compCount <= '0;
        end else begin
            runPrev <= runCmd;
            if (runCmd && !runPrev) compCount <= compEvent ? W'(STEP) : '0;
            else if (compEvent) compCount <= W'(compCount + W'(STEP));
        end
    end

    dmc_monitor_sel #(.W(W)) u_sel (
        .clk(clk),
        .nrst(nrst),
        .selCode(selCode),
        .selWrite(selWrite),
        .fullClosedEn(fullClosedEn),
        .positionFeedEn(positionFeedEn),
        .driveStopped(state == dmc_pkg::DMC_IDLE),
        .negOutEn(negOutEn),
        .serialRead(serialRead),
        .compCount(compCount),
        .posLoopComp(posLoopComp),
        .modelSpeed(modelSpeed),
        .meterFault(meterFault),
        .craneSpeed(craneSpeed),
        .genSpeed(modelSpeed),
        .droopComp(droopComp),
        .posCmd(posCmd),
        .curPos(curPos),
        .sysFault(sysFault),
        .activeSel(activeSel),
        .monValue(monValue),
        .monNegative(monNegative)
    );

    ////////////////////////////////////////////////////////////////////////
    a_wr_done: assert property (@(posedge clk) disable iff (!nrst)
        (wrReq && !wrPrev) |=> freq_write_done_bit_b && setFreq == $past(speedCommand))
        else $error("write not completed");
    a_brake_open: assert property (@(posedge clk) disable iff (!nrst)
        (state == dmc_pkg::DMC_IDLE && runCmd) |=> brake_open_request)
        else $error("brake not opened on run");
    a_brake_hold: assert property (@(posedge clk) disable iff (!nrst)
        (brake_open_request && modelSpeed != '0) |=> brake_open_request)
        else $error("brake dropped while moving");
    a_brake_drop: assert property (@(posedge clk) disable iff (!nrst)
        $fell(brake_open_request) |-> $past(modelSpeed) == '0)
        else $error("brake dropped before stop");
    a_ramp_step: assert property (@(posedge clk) disable iff (!nrst)
        (state == dmc_pkg::DMC_ACCEL && runCmd) |=> modelSpeed <= $past(modelSpeed) + $past(rampAccelStep))
        else $error("acceleration too fast");
    a_reply_good: assert property (@(posedge clk) disable iff (!nrst)
        (wrReq && !wrPrev && speedFeedStatus) |=> reply_code_word_a == `DMC_REPLY_OK)
        else $error("good write not answered with zero");
    a_done_release: assert property (@(posedge clk) disable iff (!nrst)
        !wrReq |=> !freq_write_done_bit_b)
        else $error("done held without request");
    a_idle_still: assert property (@(posedge clk) disable iff (!nrst)
        (state == dmc_pkg::DMC_IDLE) |-> modelSpeed == '0)
        else $error("model speed moving while idle");
    a_comp_restart: assert property (@(posedge clk) disable iff (!nrst)
        (runCmd && !runPrev && !compEvent) |=> compCount == '0)
        else $error("compensation count not restarted");
    c_run_cycle: cover property (@(posedge clk) disable iff (!nrst) $fell(brake_open_request));
    c_write_ok: cover property (@(posedge clk) disable iff (!nrst)
        freq_write_done_bit_b && reply_code_word_a == `DMC_REPLY_OK);
    c_at_speed: cover property (@(posedge clk) disable iff (!nrst) state == dmc_pkg::DMC_RUN);
endmodule // dmc_drive_cmd
`default_nettype wire

/* rtl/dmc_defs.svh */
// Constants for the drive monitor and command handshake block
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH
`define DMC_SEL_COMP_COUNT 8'h27
`define DMC_SEL_SPEED_CMD 8'h34
`define DMC_SEL_METER_FAULT 8'h36
`define DMC_SEL_CRANE_SPEED 8'h43
`define DMC_SEL_MODEL_SPEED 8'h51
`define DMC_SEL_GEN_SPEED 8'h5b
`define DMC_SEL_DROOP_SPEED 8'h5c
`define DMC_SEL_POS_CMD_LO 8'h5d
`define DMC_SEL_POS_CMD_HI 8'h5e
`define DMC_SEL_CUR_POS_LO 8'h5f
`define DMC_SEL_CUR_POS_HI 8'h60
`define DMC_SEL_SYS_FAULT 8'h61
`define DMC_SEL_RESET 8'h34
`define DMC_POS_SPLIT 32'h0000_2710
`define DMC_REPLY_OK 16'h0000
`define DMC_REPLY_BUSY 16'h0001
`define DMC_STOP_TIME_NS 1000
`define DMC_CLK_NS 4
`define DMC_STOP_CYCLES ((`DMC_STOP_TIME_NS + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`endif

/* rtl/dmc_pkg.sv */
// Types for the drive monitor and command handshake block
`default_nettype none
package dmc_pkg;
    typedef enum logic [3:0] {
        DMC_IDLE = 4'b0001,
        DMC_ACCEL = 4'b0010,
        DMC_RUN = 4'b0100,
        DMC_DECEL = 4'b1000
    } dmc_run_e;
endpackage
`default_nettype wire

/* rtl/dmc_monitor_sel.sv */
// Monitor item selector with zero and sign handling
`default_nettype none
`include "dmc_defs.svh"
module dmc_monitor_sel #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] selCode,
    input wire logic selWrite,
    input wire logic fullClosedEn,
    input wire logic positionFeedEn,
    input wire logic driveStopped,
    input wire logic negOutEn,
    input wire logic serialRead,
    input wire logic [W-1:0] compCount,
    input wire logic [W-1:0] posLoopComp,
    input wire logic [W-1:0] modelSpeed,
    input wire logic [W-1:0] meterFault,
    input wire logic [W-1:0] craneSpeed,
    input wire logic [W-1:0] genSpeed,
    input wire logic [W-1:0] droopComp,
    input wire logic [31:0] posCmd,
    input wire logic [31:0] curPos,
    input wire logic [W-1:0] sysFault,
    output logic [7:0] activeSel,
    output logic [W-1:0] monValue,
    output logic monNegative
);
    logic [W-1:0] next_value;
    logic signedItem;
    logic known;
    logic [W-1:0] speedCmd;
    logic [31:0] posCmdFine;
    logic [31:0] posCmdMetres;
    logic [31:0] curPosFine;
    logic [31:0] curPosMetres;

    assign speedCmd = W'(posLoopComp + modelSpeed);

    // Whole metres above, 0.1 mm remainder below; a plain bit split would not give metres
    assign posCmdFine = posCmd % `DMC_POS_SPLIT;
    assign posCmdMetres = posCmd / `DMC_POS_SPLIT;
    assign curPosFine = curPos % `DMC_POS_SPLIT;
    assign curPosMetres = curPos / `DMC_POS_SPLIT;

    always_comb begin
        known = 1'b1;
        case (selCode)
            `DMC_SEL_COMP_COUNT, `DMC_SEL_SPEED_CMD, `DMC_SEL_METER_FAULT, `DMC_SEL_CRANE_SPEED,
            `DMC_SEL_MODEL_SPEED, `DMC_SEL_GEN_SPEED, `DMC_SEL_DROOP_SPEED, `DMC_SEL_POS_CMD_LO,
            `DMC_SEL_POS_CMD_HI, `DMC_SEL_CUR_POS_LO, `DMC_SEL_CUR_POS_HI, `DMC_SEL_SYS_FAULT: known = 1'b1;
            default: known = 1'b0;
        endcase
    end

    // Unknown codes keep the old item
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            activeSel <= `DMC_SEL_RESET;
        end else if (selWrite && known) begin
            activeSel <= selCode;
        end
    end

    always_comb begin
        next_value = '0;
        signedItem = 1'b0;
        case (activeSel)
            `DMC_SEL_COMP_COUNT: next_value = compCount;
            `DMC_SEL_SPEED_CMD: begin
                next_value = fullClosedEn ? speedCmd : '0;
                signedItem = 1'b1;
            end
            `DMC_SEL_METER_FAULT: next_value = meterFault;
            `DMC_SEL_CRANE_SPEED: begin
                next_value = fullClosedEn ? craneSpeed : '0;
                signedItem = 1'b1;
            end
            `DMC_SEL_MODEL_SPEED: begin
                next_value = fullClosedEn ? modelSpeed : '0;
                signedItem = 1'b1;
            end
            `DMC_SEL_GEN_SPEED: begin
                next_value = fullClosedEn ? genSpeed : '0;
                signedItem = 1'b1;
            end
            `DMC_SEL_DROOP_SPEED: begin
                next_value = fullClosedEn ? W'(speedCmd + droopComp) : '0;
                signedItem = 1'b1;
            end
            `DMC_SEL_POS_CMD_LO: next_value = (positionFeedEn && !driveStopped) ? W'(posCmdFine) : '0;
            `DMC_SEL_POS_CMD_HI: next_value = (positionFeedEn && !driveStopped) ? W'(posCmdMetres) : '0;
            `DMC_SEL_CUR_POS_LO: next_value = W'(curPosFine);
            `DMC_SEL_CUR_POS_HI: next_value = W'(curPosMetres);
            `DMC_SEL_SYS_FAULT: next_value = sysFault;
            default: next_value = '0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            monValue <= '0;
            monNegative <= 1'b0;
        end else begin
            monValue <= next_value;
            // Serial links cannot carry a sign
            monNegative <= signedItem && negOutEn && !serialRead && next_value[W-1];
        end
    end

    a_sel_keep: assert property (@(posedge clk) disable iff (!nrst)
        (selWrite && !known) |=> activeSel == $past(activeSel))
        else $error("unknown code changed selection");
    a_serial_nosign: assert property (@(posedge clk) disable iff (!nrst)
        $past(serialRead) |-> !monNegative)
        else $error("sign shown on serial read");
    a_sign_gate: assert property (@(posedge clk) disable iff (!nrst)
        monNegative |-> $past(negOutEn))
        else $error("sign shown while disabled");
    a_fc_zero: assert property (@(posedge clk) disable iff (!nrst)
        (!fullClosedEn && activeSel == `DMC_SEL_CRANE_SPEED) |=> monValue == '0)
        else $error("crane speed not zero");
    a_pos_zero: assert property (@(posedge clk) disable iff (!nrst)
        (driveStopped && activeSel == `DMC_SEL_POS_CMD_LO) |=> monValue == '0)
        else $error("position command not zero");
    a_sys_fault: assert property (@(posedge clk) disable iff (!nrst)
        (activeSel == `DMC_SEL_SYS_FAULT) |=> monValue == $past(sysFault))
        else $error("system fault code wrong");
    c_sel_change: cover property (@(posedge clk) disable iff (!nrst) selWrite && known);
endmodule // dmc_monitor_sel
`default_nettype wire

/* test/dmc_ctrl_model.sv */
// Network controller model: frequency write handshake and run commands
`default_nettype none
module dmc_ctrl_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic writeGo,
    input wire logic skipCheck,
    input wire logic [15:0] setSpeed,
    input wire logic runFwd,
    input wire logic runRev,
    input wire logic doneBit,
    input wire logic [15:0] reply,
    input wire logic feedStatus,
    output logic wrReq,
    output logic [15:0] speedCmd,
    output logic writeOk,
    output logic fwdRun,
    output logic revRun
);
    timeunit 1ns;
    timeprecision 100ps;
    // Acts on the rising edge so the bench's falling-edge stimulus is already settled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrReq <= 1'b0;
            speedCmd <= 16'h5a5a;
            writeOk <= 1'b0;
        end else if (!wrReq && !doneBit && writeGo && (feedStatus || skipCheck)) begin
            wrReq <= 1'b1;
            speedCmd <= setSpeed;
            writeOk <= 1'b0;
        end else if (wrReq && doneBit) begin
            wrReq <= 1'b0;
            // Released value is inverted so a stale latch cannot pass
            speedCmd <= ~speedCmd;
            writeOk <= (reply === 16'h0000);
        end
    end
    // Start only after an accepted write
    assign fwdRun = runFwd & writeOk;
    assign revRun = runRev & writeOk;
endmodule // dmc_ctrl_model
`default_nettype wire

/* test/dmc_drive_cmd_test.sv */
// Self-checking bench for the drive command and monitor block
`default_nettype none
module dmc_drive_cmd_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, nrst, writeGo, skipCheck, runFwd, runRev, wrReq, writeOk, fwdRun, revRun;
    logic speedFeedMode, fullClosedEn, positionFeedEn, negOutEn, serialRead, selWrite, compEvent;
    logic done, brake, feedStatus, monNegative;
    logic [15:0] setSpeed, speedCmd, step, posLoopComp, meterFault, craneSpeed, droopComp, sysFault;
    logic [15:0] reply, modelSpeed, monValue;
    logic [31:0] posCmd, curPos;
    logic [7:0] selCode, activeSel;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] codes [11] = '{8'h34, 8'h36, 8'h43, 8'h51, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61};
    logic [15:0] expv [11] = '{16'h0123, 16'h0042, 16'h0200, 16'h0000, 16'h0000, 16'h0134, 16'h0000,
                               16'h0000, 16'h0433, 16'h000d, 16'h0007};
    logic isSpeed [11] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    always #2 clk = ~clk;

    dmc_ctrl_model dmc_ctrl_model_i (.clk(clk), .nrst(nrst), .writeGo(writeGo), .skipCheck(skipCheck),
        .setSpeed(setSpeed), .runFwd(runFwd), .runRev(runRev), .doneBit(done), .reply(reply),
        .feedStatus(feedStatus), .wrReq(wrReq), .speedCmd(speedCmd), .writeOk(writeOk),
        .fwdRun(fwdRun), .revRun(revRun));

    dmc_drive_cmd #(.W(16), .STEP(1)) dmc_drive_cmd_i (.clk(clk), .nrst(nrst),
        .freq_write_request_bit_a(wrReq), .speedCommand(speedCmd), .forward_run_command(fwdRun),
        .reverse_run_command(revRun), .rampAccelStep(step), .rampDecelStep(step),
        .speedFeedMode(speedFeedMode), .fullClosedEn(fullClosedEn), .positionFeedEn(positionFeedEn),
        .negOutEn(negOutEn), .serialRead(serialRead), .selCode(selCode), .selWrite(selWrite),
        .compEvent(compEvent), .posLoopComp(posLoopComp), .meterFault(meterFault),
        .craneSpeed(craneSpeed), .droopComp(droopComp), .posCmd(posCmd), .curPos(curPos),
        .sysFault(sysFault), .freq_write_done_bit_b(done), .reply_code_word_a(reply),
        .brake_open_request(brake), .modelSpeed(modelSpeed), .speedFeedStatus(feedStatus),
        .activeSel(activeSel), .monValue(monValue), .monNegative(monNegative));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole run is under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Selection load takes an edge, the value one more
    task automatic sel(input logic [7:0] code);
        selCode = code;
        selWrite = 1'b1;
        tick(1);
        selWrite = 1'b0;
        tick(3);
    endtask

    task automatic do_write(input logic [15:0] speed, input logic [15:0] expReply);
        int i;
        i = 0;
        setSpeed = speed;
        writeGo = 1'b1;
        tick(1);
        writeGo = 1'b0;
        while (done !== 1'b1 && i < 12) begin
            tick(1);
            i++;
        end
        check("write done", done, 1'b1);
        check("reply code", reply, expReply);
        tick(1);
        check("write accepted", writeOk, expReply === 16'h0000);
        i = 0;
        while (done !== 1'b0 && i < 12) begin
            tick(1);
            i++;
        end
        check("done released", done, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("reset done", done, 1'b0);
        check("reset reply", reply, 16'h0000);
        check("reset brake", brake, 1'b0);
        check("reset sel", activeSel, 8'h34);
        check("reset model", modelSpeed, 16'h0000);
    endtask

    task automatic t_refused();
        speedFeedMode = 1'b0;
        skipCheck = 1'b1;
        tick(3);
        do_write(16'h0064, 16'h0001);
        runFwd = 1'b1;
        tick(10);
        check("no brake after refusal", brake, 1'b0);
        runFwd = 1'b0;
        speedFeedMode = 1'b1;
        skipCheck = 1'b0;
        tick(3);
        check("feed status", feedStatus, 1'b1);
    endtask

    task automatic t_run(input logic rev);
        int i;
        i = 0;
        runFwd = !rev;
        runRev = rev;
        while (brake !== 1'b1 && i < 8) begin
            tick(1);
            i++;
        end
        check("brake open", brake, 1'b1);
        sel(8'h27);
        check("comp count cleared", monValue, 16'h0000);
        i = 0;
        while (modelSpeed !== 16'd6000 && i < 80) begin
            tick(1);
            i++;
        end
        check("ramp to set speed", modelSpeed, 16'd6000);
        repeat (3) begin
            compEvent = 1'b1;
            tick(1);
            compEvent = 1'b0;
            tick(1);
        end
        tick(2);
        check("comp count", monValue, 16'h0003);
        sel(8'h51);
        check("model speed item", monValue, 16'd6000);
        sel(8'h34);
        check("speed cmd item", monValue, 16'd6291);
        sel(8'h5d);
        check("pos cmd low", monValue, 16'h0005);
        sel(8'h5e);
        check("pos cmd high", monValue, 16'h000a);
        positionFeedEn = 1'b0;
        tick(3);
        check("pos cmd feed off", monValue, 16'h0000);
        positionFeedEn = 1'b1;
        runFwd = 1'b0;
        runRev = 1'b0;
        i = 0;
        while (brake !== 1'b0 && i < 400) begin
            tick(1);
            i++;
        end
        check("brake closed", brake, 1'b0);
        check("stopped speed", modelSpeed, 16'h0000);
        check("settle at zero", i >= 250, 1'b1);
    endtask

    task automatic t_monitor();
        for (int fc = 1; fc >= 0; fc--) begin
            fullClosedEn = fc[0];
            for (int k = 0; k < 11; k++) begin
                sel(codes[k]);
                check("active sel", activeSel, codes[k]);
                check("item value", monValue, (fc == 0 && isSpeed[k]) ? 16'h0000 : expv[k]);
            end
        end
        fullClosedEn = 1'b1;
        sel(8'h28);
        check("unknown code", activeSel, 8'h61);
        craneSpeed = 16'hff38;
        negOutEn = 1'b1;
        sel(8'h43);
        check("sign shown", monNegative, 1'b1);
        serialRead = 1'b1;
        tick(3);
        check("serial no sign", monNegative, 1'b0);
        serialRead = 1'b0;
        negOutEn = 1'b0;
        tick(3);
        check("sign disabled", monNegative, 1'b0);
        craneSpeed = 16'h0200;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        {writeGo, skipCheck, runFwd, runRev, selWrite, compEvent, negOutEn, serialRead} = '0;
        {speedFeedMode, fullClosedEn, positionFeedEn} = 3'b111;
        setSpeed = 16'h0000;
        step = 16'h0064;
        selCode = 8'h34;
        posLoopComp = 16'h0123;
        meterFault = 16'h0042;
        craneSpeed = 16'h0200;
        droopComp = 16'h0011;
        sysFault = 16'h0007;
        posCmd = 32'h0001_86a5;
        curPos = 32'h0002_0003;
        tick(2);
        nrst = 1'b1;
        t_reset();
        t_monitor();
        t_refused();
        do_write(16'd6000, 16'h0000);
        t_run(1'b0);
        t_run(1'b1);
        stop_test();
    end
endmodule // dmc_drive_cmd_test
`default_nettype wire
